// ==== pbrh_pkg.sv ====
// Purpose: Shared constants and types for the bus release handshake
// Assumes: One clock; each CLK edge stands for one cycle clock period
// Notes:   Timing counts are in cycles of CLK

package pbrh_pkg;

  // ==========================================================
  // Geometry
  // ==========================================================
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int WAIT_W = 3;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          GRANT_MIN_NS   = 20;
  localparam logic [1:0]  GRANT_MIN_CYC  =
    2'((GRANT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  RESET_GRANT_CYC = 4'h9;
  localparam logic [WAIT_W-1:0] WAIT_RESET = 3'h7;
  localparam logic [WAIT_W-1:0] WAIT_ZERO  = 3'h0;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [2:0] {
    PBRH_IDLE    = 3'b000,
    PBRH_ACCESS  = 3'b001,
    PBRH_STROBE  = 3'b010,
    PBRH_FLOAT   = 3'b011,
    PBRH_HOLD    = 3'b100,
    PBRH_RESUME  = 3'b101
  } pbrh_state_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pbrh_req_t;

  typedef struct packed {
    logic              strobe_n;
    logic              strobe_oe;
    logic              read_n_write;
    logic              rw_oe;
    logic [ADDR_W-1:0] addr;
    logic              addr_oe;
    logic [DATA_W-1:0] data;
    logic              data_oe;
  } pbrh_bus_t;

endpackage : pbrh_pkg

// ==== pbrh_sync.sv ====
// Purpose: Two flop synchroniser for the release request pin
// Assumes: Pin is asynchronous to CLK
// Notes:   Resets to the inactive (high) level

`timescale 1ns/1ps
`default_nettype none

module pbrh_sync (
  // Clock and reset
  input  wire logic CLK,
  input  wire logic ARST_N,
  // Pin and result
  input  wire logic pin_in,
  output var  logic pin_sync
);

  logic stage1;
  logic stage2;
  logic next_stage1;
  logic next_stage2;

  always_comb begin
    next_stage1 = pin_in;
    next_stage2 = stage1;
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      stage1 <= 1'b1;
      stage2 <= 1'b1;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign pin_sync = stage2;

endmodule : pbrh_sync

`default_nettype wire

// ==== pbrh_core.sv ====
// Purpose: Primary bus release handshake on the device side
// Assumes: Core asks for accesses on a valid/ready port; one edge per cycle
// Notes:   Request pin is sampled through two flops, which adds the slip
//
// Contract
// - Request pin may change anytime; missed setup delays answer one cycle.
// - Block bit set: ignore request, leave hold, refuse new holds.
// - No primary access starts while a request is in effect.
// - During hold, one write may be parked; a second write stalls.
// - Request sampled one cycle before bus cycle end; width wait+3 cycles.
// - Grant stays low at least two cycle clock periods, unless the block bit ends hold after one.
// - Strobe driven high before strobe, select and address float.
// - In hold, data, address and select float until hold ends.
// - Request during reset: grant within nine cycles after release.

`timescale 1ns/1ps
`default_nettype none

module pbrh_core
  import pbrh_pkg::*;
(
  // Clock and reset
  input  wire logic      CLK,
  input  wire logic      ARST_N,
  // Release handshake pins
  input  wire logic      RELEASE_REQ_N,
  output var  logic      BUS_RELEASE_GRANT_N,
  // Control inputs
  input  wire logic      RELEASE_BLOCK_BIT,
  input  wire logic [WAIT_W-1:0] WAIT_STATE_COUNT,
  // Core access port
  input  wire pbrh_req_t CORE_REQ,
  output var  logic      CORE_READY,
  output var  logic [DATA_W-1:0] CORE_RDATA,
  output var  logic      WRITE_PARKED,
  // Primary bus pins
  input  wire logic [DATA_W-1:0] BUS_DATA_IN,
  output var  pbrh_bus_t BUS_OUT
);

  // ==========================================================
  // Request input
  // ==========================================================
  logic req_sync;

  pbrh_sync u_sync (
    .CLK      (CLK),
    .ARST_N   (ARST_N),
    .pin_in   (RELEASE_REQ_N),
    .pin_sync (req_sync)
  );

  logic        hold_want;
  pbrh_state_t state;
  pbrh_state_t next_state;
  logic [WAIT_W-1:0] wait_cnt;
  logic [WAIT_W-1:0] next_wait_cnt;
  logic [1:0]  grant_cnt;
  logic [1:0]  next_grant_cnt;
  logic [3:0]  boot_cnt;
  logic [3:0]  next_boot_cnt;
  logic        grant_n;
  logic        next_grant_n;
  logic        ready;
  logic        next_ready;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] next_rdata;
  pbrh_req_t   cur;
  pbrh_req_t   next_cur;
  pbrh_req_t   parked;
  pbrh_req_t   next_parked;
  pbrh_bus_t   bus;
  pbrh_bus_t   next_bus;

  // Block bit overrides the request entirely
  assign hold_want = !req_sync && !RELEASE_BLOCK_BIT;

  // ==========================================================
  // Handshake state
  // ==========================================================
  always_comb begin
    next_state     = state;
    next_wait_cnt  = wait_cnt;
    next_grant_cnt = grant_cnt;
    next_boot_cnt  = boot_cnt;
    next_grant_n   = grant_n;
    next_ready     = 1'b0;
    next_rdata     = rdata;
    next_cur       = cur;
    next_parked    = parked;
    next_bus       = bus;
    if (boot_cnt != 4'h0) begin
      next_boot_cnt = boot_cnt - 4'h1;
    end
    unique case (state)
      PBRH_IDLE: begin
        if (hold_want) begin
          // Strobe already high here; float the control lines next
          next_bus.strobe_n = 1'b1;
          next_state        = PBRH_STROBE;
        end else if (parked.valid) begin
          next_cur       = parked;
          next_wait_cnt  = WAIT_STATE_COUNT;
          next_state     = PBRH_ACCESS;
        end else if (CORE_REQ.valid && !ready) begin
          next_cur      = CORE_REQ;
          next_wait_cnt = WAIT_STATE_COUNT;
          next_state    = PBRH_ACCESS;
        end
        if (next_state == PBRH_ACCESS) begin
          next_bus.strobe_n     = 1'b0;
          next_bus.read_n_write = !next_cur.write;
          next_bus.addr         = next_cur.addr;
          next_bus.data         = next_cur.data;
          next_bus.data_oe      = next_cur.write;
        end
      end
      PBRH_ACCESS: begin
        // Hold request waits here until the access ends
        if (wait_cnt != WAIT_ZERO) begin
          next_wait_cnt = wait_cnt - 3'h1;
        end else begin
          next_bus.strobe_n = 1'b1;
          next_bus.data_oe  = 1'b0;
          next_rdata        = BUS_DATA_IN;
          // Parked write was acknowledged when parked; no second ready
          next_ready        = !parked.valid;
          next_parked       = '0;
          next_state        = PBRH_IDLE;
        end
      end
      PBRH_STROBE: begin
        if (!hold_want) begin
          next_state = PBRH_IDLE;
        end else begin
          next_bus.strobe_oe = 1'b0;
          next_bus.rw_oe     = 1'b0;
          next_bus.addr_oe   = 1'b0;
          next_bus.data_oe   = 1'b0;
          next_state         = PBRH_FLOAT;
        end
      end
      PBRH_FLOAT: begin
        if (boot_cnt == 4'h0 || !hold_want) begin
          next_grant_n   = !hold_want;
          next_grant_cnt = GRANT_MIN_CYC;
          next_state     = hold_want ? PBRH_HOLD : PBRH_RESUME;
        end
      end
      PBRH_HOLD: begin
        if (grant_cnt != 2'h0) begin
          next_grant_cnt = grant_cnt - 2'h1;
        end
        // Park the first write; later ones wait for the bus
        if (CORE_REQ.valid && CORE_REQ.write && !parked.valid
            && !ready) begin
          next_parked = CORE_REQ;
          next_ready  = 1'b1;
        end
        if (RELEASE_BLOCK_BIT || (!hold_want && grant_cnt <= 2'h1)) begin
          next_grant_n = 1'b1;
          next_state   = PBRH_RESUME;
        end
      end
      PBRH_RESUME: begin
        next_bus.strobe_oe = 1'b1;
        next_bus.rw_oe     = 1'b1;
        next_bus.addr_oe   = 1'b1;
        next_state         = PBRH_IDLE;
      end
      default: begin
        next_state = PBRH_IDLE;
      end
    endcase
    if (next_ready && !CORE_REQ.write && state != PBRH_ACCESS) begin
      next_ready = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state     <= PBRH_IDLE;
      wait_cnt  <= WAIT_ZERO;
      grant_cnt <= 2'h0;
      boot_cnt  <= RESET_GRANT_CYC - 4'h2;
      grant_n   <= 1'b1;
      ready     <= 1'b0;
      rdata     <= '0;
      cur       <= '0;
      parked    <= '0;
      bus       <= '{strobe_n: 1'b1, strobe_oe: 1'b1, read_n_write: 1'b1,
                     rw_oe: 1'b1, addr: '0, addr_oe: 1'b1, data: '0,
                     data_oe: 1'b0};
    end else begin
      state     <= next_state;
      wait_cnt  <= next_wait_cnt;
      grant_cnt <= next_grant_cnt;
      boot_cnt  <= next_boot_cnt;
      grant_n   <= next_grant_n;
      ready     <= next_ready;
      rdata     <= next_rdata;
      cur       <= next_cur;
      parked    <= next_parked;
      bus       <= next_bus;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign BUS_RELEASE_GRANT_N = grant_n;
  assign CORE_READY          = ready;
  assign CORE_RDATA          = rdata;
  assign WRITE_PARKED        = parked.valid;
  assign BUS_OUT             = bus;

endmodule : pbrh_core

`default_nettype wire

// ==== pbrh_checker.sv ====
// Purpose: Port assertions for the bus release handshake
// Assumes: Sees the ports of pbrh_core only
// Notes:   Bound below the module
`timescale 1ns/1ps
`default_nettype none
module pbrh_checker
  import pbrh_pkg::*;
(
  // Clock and reset
  input wire logic      CLK,
  input wire logic      ARST_N,
  // Watched ports
  input wire logic      BUS_RELEASE_GRANT_N,
  input wire logic      RELEASE_BLOCK_BIT,
  input wire pbrh_req_t CORE_REQ,
  input wire logic      CORE_READY,
  input wire logic      WRITE_PARKED,
  input wire pbrh_bus_t BUS_OUT
);
  // ====
  // Properties
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  wire logic gnt = !BUS_RELEASE_GRANT_N;

  AST_GRANT_MIN: assert property ($fell(BUS_RELEASE_GRANT_N) |=> gnt)
    else $error("grant too short");
  AST_STROBE_FIRST: assert property ($fell(BUS_OUT.strobe_oe) |->
    $past(BUS_OUT.strobe_n) && !BUS_OUT.addr_oe && !BUS_OUT.rw_oe)
    else $error("float order");
  AST_FLOAT: assert property (gnt |-> !BUS_OUT.strobe_oe &&
    !BUS_OUT.addr_oe && !BUS_OUT.rw_oe && !BUS_OUT.data_oe)
    else $error("bus driven in hold");
  AST_BLOCK: assert property (RELEASE_BLOCK_BIT[*2] |-> !gnt)
    else $error("grant while blocked");
  AST_ACCESS: assert property (!BUS_OUT.strobe_n |-> !gnt &&
    BUS_OUT.addr_oe && BUS_OUT.rw_oe)
    else $error("access in hold");
  AST_PARK: assert property (gnt && CORE_REQ.valid && CORE_REQ.write &&
    !WRITE_PARKED |-> ##[1:2] CORE_READY)
    else $error("write not parked");
  AST_STALL: assert property ($past(WRITE_PARKED) && gnt |-> !CORE_READY)
    else $error("second write taken");
  AST_RESUME: assert property ($rose(BUS_RELEASE_GRANT_N) |->
    !BUS_OUT.addr_oe ##1 BUS_OUT.addr_oe)
    else $error("bus not resumed");
endmodule : pbrh_checker

bind pbrh_core pbrh_checker i_pbrh_checker (
  .CLK                 (CLK),
  .ARST_N              (ARST_N),
  .BUS_RELEASE_GRANT_N (BUS_RELEASE_GRANT_N),
  .RELEASE_BLOCK_BIT   (RELEASE_BLOCK_BIT),
  .CORE_REQ            (CORE_REQ),
  .CORE_READY          (CORE_READY),
  .WRITE_PARKED        (WRITE_PARKED),
  .BUS_OUT             (BUS_OUT)
);
`default_nettype wire

// ==== pbrh_master.sv ====
// Purpose: Outside master that asks for the primary bus
// Assumes: Bench calls run at a falling edge
// Notes:   Gives up when no grant comes
`timescale 1ns/1ps
`default_nettype none
module pbrh_master
  import pbrh_pkg::*;
(
  // Handshake
  input  wire logic              CLK,
  input  wire logic              GRANT_N,
  input  wire logic [WAIT_W-1:0] WAIT_CNT,
  output var  logic              REQ_N
);
  initial REQ_N = 1'b1;
  // ====
  // Request held wait+3+extra cycles and until grant has been seen low for two cycles
  task automatic run(input int extra);
    int k;
    int g;
    k = 0;
    g = 0;
    REQ_N = 1'b0;
    while ((g < 2 || k < int'(WAIT_CNT) + 3 + extra) && k < 300) begin
      @(negedge CLK);
      k++;
      if (!GRANT_N) g++;
    end
    REQ_N = 1'b1;
  endtask : run
endmodule : pbrh_master
`default_nettype wire

// ==== testbench.sv ====
// Purpose: Self-checking bench for the bus release handshake
// Assumes: Inputs change on the falling edge of CLK
// Notes:   Outside master modelled by pbrh_master
`timescale 1ns/1ps
`default_nettype none
module testbench
  import pbrh_pkg::*;
;
  logic              CLK = 1'b0;
  logic              ARST_N = 1'b0;
  logic              req_n;
  logic              grant_n;
  logic              blk = 1'b0;
  logic [WAIT_W-1:0] wcnt = WAIT_ZERO;
  pbrh_req_t         creq = '0;
  logic              rdy;
  logic [DATA_W-1:0] rdata;
  logic              parked;
  logic [DATA_W-1:0] bdin = 32'h0000_0000;
  pbrh_bus_t         bout;
  int                fails = 0;
  int                cmp_count = 0;
  int                cyc = 0;
  int                n;
  int                k;
  logic [31:0]       q;

  always #5 CLK = ~CLK;

  pbrh_core i_pbrh_core (.CLK(CLK), .ARST_N(ARST_N), .RELEASE_REQ_N(req_n),
    .BUS_RELEASE_GRANT_N(grant_n), .RELEASE_BLOCK_BIT(blk),
    .WAIT_STATE_COUNT(wcnt), .CORE_REQ(creq), .CORE_READY(rdy),
    .CORE_RDATA(rdata), .WRITE_PARKED(parked), .BUS_DATA_IN(bdin),
    .BUS_OUT(bout));
  pbrh_master i_pbrh_master (.CLK(CLK), .GRANT_N(grant_n), .WAIT_CNT(wcnt),
    .REQ_N(req_n));

  // ====
  // Helpers
  task automatic summarize();
    if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  always @(posedge CLK) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wait_grant(input logic v, output int c);
    c = 0;
    while (grant_n !== v && c < 60) begin
      @(negedge CLK);
      c++;
    end
  endtask : wait_grant

  task automatic core_op(input logic wr, input logic [31:0] d,
                         output int c, output logic [31:0] r);
    c = 0;
    creq = '{1'b1, wr, 24'h00_0040, d};
    do begin
      @(negedge CLK);
      c++;
    end while (rdy !== 1'b1 && c < 60);
    r = rdata;
    creq.valid = 1'b0;
  endtask : core_op

  task automatic held();
    chk({28'h0, bout.strobe_oe, bout.rw_oe, bout.addr_oe, bout.data_oe},
        32'h0);
    wait_grant(1'b1, k);
    @(negedge CLK);
    chk({28'h0, bout.strobe_oe, bout.rw_oe, bout.addr_oe, bout.data_oe},
        32'he);
  endtask : held

  // ====
  // Scenarios
  task automatic s_reset_req();
    @(negedge CLK);
    fork
      i_pbrh_master.run(0);
    join_none
    repeat (11) @(negedge CLK);
    ARST_N = 1'b1;
    wait_grant(1'b0, n);
    chk(32'(n <= int'(RESET_GRANT_CYC)), 32'h1);
    held();
  endtask : s_reset_req

  task automatic s_idle();
    fork
      i_pbrh_master.run(0);
    join_none
    wait_grant(1'b0, n);
    chk(32'(n >= 4 && n <= 6), 32'h1);
    held();
  endtask : s_idle

  task automatic s_busy();
    wcnt = 3'h7;
    bdin = 32'ha5a5_0f0f;
    fork
      core_op(1'b0, 32'h0, k, q);
      begin
        repeat (2) @(negedge CLK);
        i_pbrh_master.run(0);
      end
      wait_grant(1'b0, n);
    join
    chk(q, 32'ha5a5_0f0f);
    chk(32'(n > k), 32'h1);
    wait_grant(1'b1, n);
    @(negedge CLK);
    wcnt = WAIT_ZERO;
  endtask : s_busy

  task automatic s_park();
    fork
      i_pbrh_master.run(24);
    join_none
    wait_grant(1'b0, n);
    core_op(1'b1, 32'h1111_2222, k, q);
    chk(32'(k <= 2), 32'h1);
    chk({31'h0, parked}, 32'h1);
    @(negedge CLK);
    fork
      core_op(1'b1, 32'h3333_4444, k, q);
      begin
        wait_grant(1'b1, n);
        repeat (2) @(negedge CLK);
        chk(32'({bout.strobe_n, bout.read_n_write, bout.data_oe}),
            32'h1);
        chk(bout.data, 32'h1111_2222);
        chk(32'(bout.addr), 32'h0000_0040);
      end
    join
    chk(32'(k > n), 32'h1);
    chk({31'h0, parked}, 32'h0);
    chk(bout.data, 32'h3333_4444);
  endtask : s_park

  task automatic s_block();
    fork
      i_pbrh_master.run(30);
    join_none
    wait_grant(1'b0, n);
    @(negedge CLK);
    blk = 1'b1;
    wait_grant(1'b1, n);
    chk(32'(n <= 2), 32'h1);
    repeat (40) @(negedge CLK);
    chk({31'h0, grant_n}, 32'h1);
    blk = 1'b0;
  endtask : s_block

  initial begin
    s_reset_req();
    s_idle();
    s_busy();
    s_park();
    s_block();
    summarize();
  end
endmodule : testbench
`default_nettype wire
